// ===== common/ssc_regs.vh
// register map, field positions and reset values of the sysref capture block
`ifndef SSC_REGS_VH
`define SSC_REGS_VH

// register indices; byte address is four times the index
`define SSC_IDX_W      10
`define SSC_IDX_CFG    10'h120
`define SSC_IDX_SKIP   10'h121
`define SSC_IDX_SKEW   10'h122
`define SSC_IDX_STAT   10'h12f

// capture config fields
`define SSC_CFG_FLAGRST 6
`define SSC_CFG_POL     4
`define SSC_CFG_EDGE    3
`define SSC_CFG_MODE_HI 2
`define SSC_CFG_MODE_LO 1

// skew window fields
`define SSC_SKEW_NEG_HI 3
`define SSC_SKEW_NEG_LO 2
`define SSC_SKEW_POS_HI 1
`define SSC_SKEW_POS_LO 0

// writable bits; reserved bits read as zero
`define SSC_CFG_MASK   8'h5e
`define SSC_SKIP_MASK  8'h0f
`define SSC_SKEW_MASK  8'h0f

// reset values
`define SSC_CFG_RST    8'h00
`define SSC_SKIP_RST   8'h00
`define SSC_SKEW_RST   8'h00

// capture modes
`define SSC_MODE_OFF   2'h0
`define SSC_MODE_CONT  2'h1
`define SSC_MODE_NSHOT 2'h2

// axi responses
`define SSC_RESP_OKAY   2'h0
`define SSC_RESP_SLVERR 2'h2

// sysref period in sample clocks, used for the expected phase
`define SSC_PERIOD     16
`define SSC_PHASE_W    4

`endif

// ===== logic/ssc_sync.v
// three-stage synchroniser with agreement filter for pin inputs
`default_nettype none

module ssc_sync #(
  parameter W = 2
) (
  // clock and reset
  input  wire         clk,
  input  wire         nrst,
  input  wire         ce,
  // raw pins and filtered result
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);

  reg [W-1:0] s1_reg;  // metastable stage, read only by s2
  reg [W-1:0] s2_reg;  // second stage
  reg [W-1:0] s3_reg;  // third stage

  // shift chain; output follows once stages two and three agree
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= {W{1'b0}};
      s2_reg <= {W{1'b0}};
      s3_reg <= {W{1'b0}};
      dout   <= {W{1'b0}};
    end else if (ce) begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // per bit, so one noisy pin cannot hold back the other
      dout   <= (s2_reg & s3_reg) | (dout & (s2_reg ^ s3_reg));
    end
  end

endmodule // ssc_sync

`default_nettype wire

// ===== logic/ssc_top.v
// sysref capture control with axi4-lite register slave
// Notes on behaviour
// - flag-reset bit holds setup/hold flags cleared
// - polarity zero: only rising sysref transitions valid
// - polarity one: only falling sysref transitions valid
// - edge select zero: sample on converter clock rise
// - edge select one: sample on converter clock fall
// - mode: 0 disabled, 1 continuous, 2 one-shot
// - skip count zero captures next valid transition
// - one-shot skips skip-count transitions, then captures
// - negative window: zero to three clocks early ignored
// - positive window: late tolerance in sample clocks
// - negative window zero gives no early tolerance
// - positive 00 none, 01..11 one to three
`include "ssc_regs.vh"
`default_nettype none

module ssc_top #(
  parameter AW     = 12,
  parameter PERIOD = `SSC_PERIOD,
  parameter PW     = `SSC_PHASE_W
) (
  // clock, reset, enable
  input  wire          clk,
  input  wire          nrst,
  input  wire          ce,
  // pins from clock generator and converter clock
  input  wire          sysref_pin,
  input  wire          conv_clk_pin,
  // capture results
  output reg           capture_pulse,
  output reg           setup_err,
  output reg           hold_err,
  // axi4-lite write address
  input  wire [AW-1:0] s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output wire          s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output wire          s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  // axi4-lite read address
  input  wire [AW-1:0] s_axi_araddr,
  input  wire          s_axi_arvalid,
  output wire          s_axi_arready,
  // axi4-lite read data
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready
);

  // software registers
  reg  [7:0]          cfg_reg;       // capture config
  reg  [7:0]          skip_reg;      // one-shot skip count
  reg  [7:0]          skew_reg;      // skew windows
  // write channel holding state
  reg                 aw_held_reg;   // address taken, waiting
  reg  [`SSC_IDX_W-1:0] aw_idx_reg;  // held write index
  reg                 w_held_reg;    // data taken, waiting
  reg  [7:0]          w_data_reg;    // held low byte
  reg                 w_lane_reg;    // byte lane 0 strobe
  // capture state
  reg                 sref_prev_reg; // sysref at previous tick
  reg                 conv_prev_reg; // converter clock last cycle
  reg  [PW-1:0]       phase_reg;     // sample clocks since expected
  reg                 locked_reg;    // phase reference established
  reg  [3:0]          skip_left_reg; // transitions still to skip
  reg                 done_reg;      // one-shot finished
  // decoded fields
  wire                flag_rst;
  wire                pol_sel;
  wire                edge_sel;
  wire [1:0]          mode;
  wire [1:0]          neg_win;
  wire [1:0]          pos_win;
  // synchronised pins
  wire [1:0]          pins_s;
  wire                sref_s;
  wire                conv_s;
  // event terms
  wire                tick;          // chosen converter clock edge
  wire                trans;         // valid sysref transition
  wire                active;        // mode allows capture now
  wire                take;          // transition reaches window test
  wire                on_time;
  wire                in_window;
  wire                early;
  wire                realign;       // capture moves the phase
  wire                hit;           // capture reported
  // bus terms
  wire                wr_go;
  wire [`SSC_IDX_W-1:0] ar_idx;
  wire                ar_go;
  reg  [7:0]          rd_byte;
  reg                 rd_ok;

  assign flag_rst = cfg_reg[`SSC_CFG_FLAGRST];
  assign pol_sel  = cfg_reg[`SSC_CFG_POL];
  assign edge_sel = cfg_reg[`SSC_CFG_EDGE];
  assign mode     = cfg_reg[`SSC_CFG_MODE_HI:`SSC_CFG_MODE_LO];
  assign neg_win  = skew_reg[`SSC_SKEW_NEG_HI:`SSC_SKEW_NEG_LO];
  assign pos_win  = skew_reg[`SSC_SKEW_POS_HI:`SSC_SKEW_POS_LO];

  // both pins come from outside this clock
  ssc_sync #(
    .W (2)
  ) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .ce   (ce),
    .din  ({conv_clk_pin, sysref_pin}),
    .dout (pins_s)
  );

  assign sref_s = pins_s[0];
  assign conv_s = pins_s[1];

  // converter clock is oversampled, so it must stay well below clk / 4
  assign tick = edge_sel ? (conv_prev_reg & ~conv_s)
                         : (~conv_prev_reg & conv_s);

  // polarity picks which transition counts
  assign trans = tick & (pol_sel ? (sref_prev_reg & ~sref_s)
                                 : (~sref_prev_reg & sref_s));

  // mode decode; value 3 captures nothing, as disabled does, but keeps the phase lock
  assign active = (mode == `SSC_MODE_CONT) ||
                  ((mode == `SSC_MODE_NSHOT) && !done_reg);

  // one-shot passes only once the skip count is used up
  assign take = trans && active &&
                ((mode != `SSC_MODE_NSHOT) ||
                 (skip_left_reg == 4'h0));

  ssc_window #(
    .PERIOD (PERIOD),
    .PW     (PW)
  ) u_win (
    .phase     (phase_reg),
    .neg_win   (neg_win),
    .pos_win   (pos_win),
    .on_time   (on_time),
    .in_window (in_window),
    .early     (early)
  );

  // once locked, a transition inside a window is disregarded entirely
  assign realign = take && (!locked_reg || (!on_time && !in_window));
  assign hit     = take && (!locked_reg || on_time || !in_window);

  // sample point history
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      conv_prev_reg <= 1'b0;
      sref_prev_reg <= 1'b0;
    end else if (ce) begin
      conv_prev_reg <= conv_s;
      if (tick) begin
        sref_prev_reg <= sref_s;
      end
    end
  end

  // phase counter in sample clocks; a capture makes this tick phase zero
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_reg  <= {PW{1'b0}};
      locked_reg <= 1'b0;
    end else if (ce) begin
      if (mode == `SSC_MODE_OFF) begin
        // disabling drops the reference, next capture starts fresh
        locked_reg <= 1'b0;
      end else if (realign) begin
        locked_reg <= 1'b1;
      end
      if (realign) begin
        phase_reg <= {{(PW-1){1'b0}}, 1'b1};
      end else if (tick) begin
        if (phase_reg == PERIOD[PW-1:0] - {{(PW-1){1'b0}}, 1'b1}) begin
          phase_reg <= {PW{1'b0}};
        end else begin
          phase_reg <= phase_reg + {{(PW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // one-shot skip counting, rearmed by any config or skip write that strobes byte lane 0
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      skip_left_reg <= 4'h0;
      done_reg      <= 1'b0;
    end else if (ce) begin
      if (wr_go && w_lane_reg &&
          (aw_idx_reg == `SSC_IDX_CFG || aw_idx_reg == `SSC_IDX_SKIP)) begin
        // reload from new skip value when it is the one being written
        skip_left_reg <= (aw_idx_reg == `SSC_IDX_SKIP) ?
                         w_data_reg[3:0] : skip_reg[3:0];
        done_reg      <= 1'b0;
      end else if (trans && active && mode == `SSC_MODE_NSHOT) begin
        if (skip_left_reg != 4'h0) begin
          skip_left_reg <= skip_left_reg - 4'h1;
        end else if (hit) begin
          done_reg <= 1'b1;
        end
      end
    end
  end

  // capture pulse and error flags
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      capture_pulse <= 1'b0;
      setup_err     <= 1'b0;
      hold_err      <= 1'b0;
    end else if (ce) begin
      capture_pulse <= hit;
      if (flag_rst) begin
        // reset control overrides any new error
        setup_err <= 1'b0;
        hold_err  <= 1'b0;
      end else if (realign && locked_reg) begin
        // off-time capture against an established phase
        if (early) begin
          setup_err <= 1'b1;
        end else begin
          hold_err  <= 1'b1;
        end
      end
    end
  end

  // write side: take address and data independently
  assign s_axi_awready = ce & ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ce & ~w_held_reg & ~s_axi_bvalid;
  assign wr_go         = aw_held_reg & w_held_reg & ~s_axi_bvalid;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_held_reg  <= 1'b0;
      aw_idx_reg   <= {`SSC_IDX_W{1'b0}};
      w_held_reg   <= 1'b0;
      w_data_reg   <= 8'h00;
      w_lane_reg   <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SSC_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_idx_reg  <= s_axi_awaddr[`SSC_IDX_W+1:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_lane_reg <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        // both halves present: answer and free the channels
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_idx_reg == `SSC_IDX_CFG  ||
                         aw_idx_reg == `SSC_IDX_SKIP ||
                         aw_idx_reg == `SSC_IDX_SKEW ||
                         aw_idx_reg == `SSC_IDX_STAT) ?
                        `SSC_RESP_OKAY : `SSC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register store; status is read only, write is accepted and dropped
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_reg  <= `SSC_CFG_RST;
      skip_reg <= `SSC_SKIP_RST;
      skew_reg <= `SSC_SKEW_RST;
    end else if (ce && wr_go && w_lane_reg) begin
      // polarity must only change while disabled; not policed here
      if (aw_idx_reg == `SSC_IDX_CFG) begin
        cfg_reg <= w_data_reg & `SSC_CFG_MASK;
      end
      if (aw_idx_reg == `SSC_IDX_SKIP) begin
        skip_reg <= w_data_reg & `SSC_SKIP_MASK;
      end
      if (aw_idx_reg == `SSC_IDX_SKEW) begin
        // field layout gives 00 none through 11 three clocks
        skew_reg <= w_data_reg & `SSC_SKEW_MASK;
      end
    end
  end

  // read side: one read in flight, answered one cycle later
  assign s_axi_arready = ce & ~s_axi_rvalid;
  assign ar_idx        = s_axi_araddr[`SSC_IDX_W+1:2];
  assign ar_go         = s_axi_arvalid & s_axi_arready;

  // read mux
  always @* begin
    rd_byte = 8'h00;
    rd_ok   = 1'b1;
    case (ar_idx)
      `SSC_IDX_CFG:  rd_byte = cfg_reg;
      `SSC_IDX_SKIP: rd_byte = skip_reg;
      `SSC_IDX_SKEW: rd_byte = skew_reg;
      `SSC_IDX_STAT: rd_byte = {skip_left_reg, done_reg, locked_reg,
                                hold_err, setup_err};
      default:       rd_ok   = 1'b0;
    endcase
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `SSC_RESP_OKAY;
    end else if (ce) begin
      if (ar_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_byte};
        s_axi_rresp  <= rd_ok ? `SSC_RESP_OKAY : `SSC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // ssc_top

`default_nettype wire

// ===== logic/ssc_window.v
// classifies a sysref transition against the expected sample clock phase
`default_nettype none

module ssc_window #(
  parameter PERIOD = 16,
  parameter PW     = 4
) (
  // phase since the expected sample clock
  input  wire [PW-1:0] phase,
  // window sizes in sample clocks
  input  wire [1:0]    neg_win,
  input  wire [1:0]    pos_win,
  // classification
  output wire          on_time,
  output wire          in_window,
  output wire          early
);

  wire [PW:0] late_by;   // sample clocks after expected
  wire [PW:0] early_by;  // sample clocks before next expected
  wire        in_neg;    // inside negative tolerance
  wire        in_pos;    // inside positive tolerance

  assign late_by   = {1'b0, phase};
  assign early_by  = PERIOD[PW:0] - late_by;
  assign on_time   = (phase == {PW{1'b0}});
  // zero setting leaves no tolerance at all
  assign in_neg    = !on_time && (early_by <= {{(PW-1){1'b0}}, neg_win});
  assign in_pos    = !on_time && (late_by <= {{(PW-1){1'b0}}, pos_win});
  assign in_window = in_neg || in_pos;
  // second half of the period counts as arriving early
  assign early     = (late_by >= (PERIOD[PW:0] >> 1));

endmodule // ssc_window

`default_nettype wire

// ===== testbench/ssc_checker.sv
// assertion checker for the sysref capture block
`default_nettype none
module ssc_checker #(parameter AW = 12) (
  // clock and reset
  input wire logic          clk,
  input wire logic          nrst,
  // capture results
  input wire logic          capture_pulse,
  input wire logic          setup_err,
  input wire logic          hold_err,
  // register bus
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic          s_axi_awvalid,
  input wire logic          s_axi_awready,
  input wire logic [31:0]   s_axi_wdata,
  input wire logic [3:0]    s_axi_wstrb,
  input wire logic          s_axi_wvalid,
  input wire logic          s_axi_wready,
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_bready,
  input wire logic          s_axi_arvalid,
  input wire logic          s_axi_arready,
  input wire logic          s_axi_rvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cfg_sh;                    // shadow of the capture config
  wire        off = cfg_sh[2] == cfg_sh[1]; // modes 0 and 3 capture nothing
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // shadow follows stored writes; address and data arrive together here
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) cfg_sh <= 8'h00;
    else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
             && s_axi_wstrb[0] && s_axi_awaddr == 12'h480) cfg_sh <= s_axi_wdata[7:0];
  end
  a_flag_hold: assert property (
    cfg_sh[6] && $past(cfg_sh[6], 3) |-> !setup_err && !hold_err) else $error("flag held");
  a_off_quiet: assert property (
    off && $past(off, 3) |-> !capture_pulse) else $error("pulse while off");
  a_pulse_one: assert property (
    capture_pulse |=> !capture_pulse) else $error("long pulse");
  a_setup_sticky: assert property (
    setup_err && !cfg_sh[6] |=> setup_err) else $error("setup flag lost");
  a_hold_sticky: assert property (
    hold_err && !cfg_sh[6] |=> hold_err) else $error("hold flag lost");
  // an off-time capture raises its flag in the very cycle its pulse stands
  a_err_cause: assert property (
    $rose(setup_err || hold_err) |-> capture_pulse) else $error("flag without capture");
  // both halves are held one edge, the answer is registered on the next
  a_wr_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid) else $error("no write answer");
  a_b_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("response dropped");
  a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid) else $error("no read answer");
endmodule // ssc_checker
`default_nettype wire

// ===== testbench/ssc_clkgen.sv
// model of the clock generator: free converter clock, sysref on command
`default_nettype none
module ssc_clkgen #(parameter int HALF = 300) (
  // sampling edge chosen by the bench
  input  wire logic edge_fall,
  // pins towards the block
  output var  logic conv_clk_pin,
  output var  logic sysref_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  int tcnt = 0;  // quiet edges seen, one per tick
  // free clock, phase unrelated to the system clock
  initial begin
    conv_clk_pin = 1'b0;
    sysref_pin = 1'b0;
    #137;
    forever #HALF conv_clk_pin = ~conv_clk_pin;
  end
  // count the edge opposite the sampling one
  always @(conv_clk_pin) if (conv_clk_pin == edge_fall) tcnt++;
  // move one system clock after a quiet edge: settled well before sampling
  task automatic set_at(input int t, input logic lvl);
    wait (tcnt >= t);
    #50 sysref_pin = lvl;
  endtask
endmodule // ssc_clkgen
`default_nettype wire

// ===== testbench/ssc_top_tb.sv
// self-checking bench for the sysref capture block
`default_nettype none
module ssc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // clock, reset and pins
  logic        clk = 1'b0, nrst = 1'b0, ce = 1'b1, edge_fall = 1'b0;
  logic        conv_clk_pin, sysref_pin, capture_pulse, setup_err, hold_err;
  // register bus
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int          err_count = 0, check_count = 0, pcnt = 0, t;
  ssc_top u_ssc_top (.clk, .nrst, .ce, .sysref_pin, .conv_clk_pin, .capture_pulse,
    .setup_err, .hold_err, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  ssc_clkgen u_ssc_clkgen (.edge_fall, .conv_clk_pin, .sysref_pin);
  initial forever #25 clk = ~clk;
  // tally of capture pulses
  always @(posedge clk) if (capture_pulse === 1'b1) pcnt++;
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // no cycle count assumed: only the watchdog ends a hang
    do begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    cmp(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    cmp(s_axi_rdata, {24'h0, d});
    cmp(s_axi_rresp, er);
  endtask
  task automatic cfg(input logic [7:0] v);
    wr(12'h480, v, 2'h0);
  endtask
  // one sysref move at tick t, then count pulses in a short window
  task automatic ev(input int t, input logic lvl, input int exp);
    int n;
    u_ssc_clkgen.set_at(t, lvl);
    n = pcnt;
    repeat (15) @(posedge clk);
    cmp(pcnt - n, exp);
  endtask
  task automatic t_regs();
    rd(12'h480, 8'h00, 2'h0);
    rd(12'h484, 8'h00, 2'h0);
    rd(12'h488, 8'h00, 2'h0);
    wr(12'h480, 8'hff, 2'h0);
    wr(12'h484, 8'hff, 2'h0);
    wr(12'h488, 8'hff, 2'h0);
    rd(12'h480, 8'h5e, 2'h0);
    rd(12'h484, 8'h0f, 2'h0);
    rd(12'h488, 8'h0f, 2'h0);
    wr(12'h4c0, 8'h01, 2'h2);
    rd(12'h4c0, 8'h00, 2'h2);
    cfg(8'h00);
    wr(12'h484, 8'h00, 2'h0);
    $display("test regs done");
  endtask
  // pulse must follow the chosen converter edge within the window
  task automatic t_edge();
    for (int e = 0; e < 2; e++) begin
      cfg(8'h00);
      edge_fall = e[0];
      cfg(8'h02 | 8'(e * 8));
      t = u_ssc_clkgen.tcnt;
      ev(t + 2, 1'b1, 1);
      ev(t + 4, 1'b0, 0);
    end
    cfg(8'h00);
    edge_fall = 1'b0;
    $display("test edge done");
  endtask
  task automatic t_pol();
    cfg(8'h10);
    cfg(8'h12);
    t = u_ssc_clkgen.tcnt;
    ev(t + 2, 1'b1, 0);
    ev(t + 4, 1'b0, 1);
    cfg(8'h10);
    cfg(8'h00);
    $display("test polarity done");
  endtask
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      cfg(8'h00);
      cfg(8'(m * 2));
      t = u_ssc_clkgen.tcnt;
      ev(t + 2, 1'b1, (m == 1 || m == 2));
      ev(t + 6, 1'b0, 0);
      ev(t + 18, 1'b1, (m == 1));
      ev(t + 22, 1'b0, 0);
    end
    cfg(8'h00);
    $display("test modes done");
  endtask
  task automatic t_skip(input int k);
    wr(12'h484, 8'(k), 2'h0);
    cfg(8'h04);
    t = u_ssc_clkgen.tcnt;
    for (int i = 0; i <= k + 1; i++) begin
      ev(t + 2 + 16 * i, 1'b1, (i == k));
      ev(t + 6 + 16 * i, 1'b0, 0);
    end
    cfg(8'h00);
    // status: count reloaded by the config write, not done, unlocked, no flags
    rd(12'h4bc, 8'(k * 16), 2'h0);
    $display("test skip done");
  endtask
  // second transition d ticks after the locking one; {neg,pos}; {pulse,setup,hold}
  task automatic t_win();
    int d[8] = '{16, 17, 17, 19, 19, 15, 13, 13};
    logic [3:0] sk[8] = '{4'h0, 4'h0, 4'h1, 4'h3, 4'h2, 4'h0, 4'hc, 4'h8};
    logic [2:0] ex[8] = '{3'h4, 3'h5, 3'h0, 3'h0, 3'h5, 3'h6, 3'h0, 3'h6};
    int dd;  // spacing of the second transition in this pass
    for (int i = 0; i < 9; i++) begin
      if (i < 8) wr(12'h488, {4'h0, sk[i]}, 2'h0);
      cfg(i < 8 ? 8'h02 : 8'h42);
      t = u_ssc_clkgen.tcnt;
      // last pass repeats the early off-time case with flags held in reset
      dd = d[i < 8 ? i : 7];
      ev(t + 2, 1'b1, 1);
      ev(t + 6, 1'b0, 0);
      ev(t + 2 + dd, 1'b1, (i < 8 ? ex[i][2] : 1));
      ev(t + 6 + dd, 1'b0, 0);
      cmp(setup_err, (i < 8 ? ex[i][1] : 0));
      cmp(hold_err, (i < 8 ? ex[i][0] : 0));
      cfg(8'h40);
      repeat (2) @(posedge clk);
      cmp(setup_err | hold_err, 0);
      cfg(8'h00);
    end
    $display("test windows done");
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // watchdog well beyond the expected run
  initial begin
    #3000000;
    err_count++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (8) @(posedge clk);
    t_regs();
    t_edge();
    t_pol();
    t_modes();
    t_skip(15);
    t_skip(3);
    t_win();
    summarize();
  end
endmodule // ssc_top_tb
bind ssc_top ssc_checker #(.AW(AW)) u_ssc_checker (.clk, .nrst, .capture_pulse,
  .setup_err, .hold_err, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
`default_nettype wire
